// ===== src/pcsan_defs.svh
// register indices, field positions, reset values and bus codes
`ifndef PCSAN_DEFS_SVH
`define PCSAN_DEFS_SVH

// register indices; byte address on the bus is four times the index
`define PCSAN_IDX_LP_BASE 10'h005
`define PCSAN_IDX_AN_EXP 10'h006
`define PCSAN_IDX_NP_TX 10'h007
`define PCSAN_IDX_NP_RX 10'h008
`define PCSAN_IDX_EXT_STAT 10'h00f
`define PCSAN_IDX_AN_IRQ 10'h010
`define PCSAN_IDX_LB_POS 10'h011
`define PCSAN_IDX_LB_CTRL 10'h012

// field positions shared by the page-shaped registers
`define PCSAN_NP_BIT 15
`define PCSAN_ACK_BIT 14
`define PCSAN_MP_BIT 13
`define PCSAN_ACK2_BIT 12
`define PCSAN_TOG_BIT 11
`define PCSAN_RF_HI 13
`define PCSAN_RF_LO 12
`define PCSAN_CODE_HI 10
`define PCSAN_CODE_LO 0
`define PCSAN_PAUSE_HI 8
`define PCSAN_PAUSE_LO 7
`define PCSAN_HD_BIT 6
`define PCSAN_FD_BIT 5
`define PCSAN_NPA_BIT 2
`define PCSAN_PRX_BIT 1
`define PCSAN_XFD_BIT 15
`define PCSAN_IRQ_ST_BIT 1
`define PCSAN_IRQ_EN_BIT 0
`define PCSAN_LB_BIT 0

// reset values and bus response codes
`define PCSAN_TX_MP_RST 1'h1
`define PCSAN_TX_CODE_RST 11'h001
`define PCSAN_IRQ_EN_RST 1'h1
`define PCSAN_RESP_OKAY 2'h0
`define PCSAN_RESP_DECERR 2'h3

`endif

// ===== src/pcsan_pkg.sv
// types shared by the auto-negotiation management register bank
`default_nettype none
package pcsan_pkg;

  // axi4-lite signals driven by the master
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } pcsan_axil_req_t;

  // axi4-lite signals driven by this slave
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pcsan_axil_rsp_t;

  // a page delivered by the negotiation engine
  typedef struct packed {
    logic valid;
    logic is_next;
    logic [15:0] word;
  } pcsan_page_t;

  // bus-side state of the slave
  typedef struct packed {
    logic aw_full;
    logic [9:0] aw_idx;
    logic w_full;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } pcsan_bus_t;

  // register contents
  typedef struct packed {
    logic lp_np, lp_ack, lp_hd, lp_fd;
    logic [1:0] lp_rf;
    logic [1:0] lp_pause;
    logic page_rx;
    logic tx_np, tx_mp, tx_ack2, tx_tog;
    logic [10:0] tx_code;
    logic rx_np, rx_ack, rx_mp, rx_ack2, rx_tog;
    logic [10:0] rx_code;
    logic irq_stat, irq_en, lb_pos, lb_en;
  } pcsan_regs_t;

  typedef struct packed {
    pcsan_bus_t bus;
    pcsan_regs_t regs;
  } pcsan_state_t;

endpackage
`default_nettype wire

// ===== src/pcsan_regs.sv
// auto-negotiation management registers 5 to 18 behind an axi4-lite slave
`include "pcsan_defs.svh"
`default_nettype none

// What this block does
// R1: partner next-page ability, read-only, resets 0
// R2: partner ack set on received page
// R3: partner pause field read-only, resets 00
// R4: partner half and full duplex bits
// R5: expansion next-page-able bit always reads 1
// R6: page-received flag, clears on expansion read
// R7: writable transmit next-page bit, default 0
// R8: message-page default 1, code default null
// R9: transmit toggle alternates per sent page
// R10: receive register captures partner next page
// R11: receive ack set on received page
// R12: receive toggle mirrors partner, resets 0
// R13: extended status 1000BASE-X full duplex reads 1
// R14: other extended abilities always read 0
// R15: enabled interrupt sets on negotiation completion
// R16: interrupt status holds until written 0
// R17: interrupt status forced 0 while disabled
// R18: interrupt output follows status bit directly
// R19: interrupt enable writable, resets to 1
// R20: loopback position select, reset from attribute
// R21: loopback acts only when enabled
// R22: reserved bits read zero, writes ignored
module pcsan_regs #(
  parameter logic loopback_position_init_attr = 1'h0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire pcsan_pkg::pcsan_axil_req_t axil_req,
  output pcsan_pkg::pcsan_axil_rsp_t axil_rsp,
  // negotiation engine side
  input wire pcsan_pkg::pcsan_page_t page_rx,
  input wire logic np_tx_sent,
  input wire logic an_complete,
  output logic [15:0] np_tx_word,
  // loopback steering
  output logic loopback_mac_en,
  output logic loopback_xcvr_en,
  // interrupt
  output logic autoneg_done_irq_out
);

  pcsan_pkg::pcsan_state_t st_q;
  pcsan_pkg::pcsan_state_t st_d;
  logic awready_c;
  logic wready_c;
  logic arready_c;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [16:0] rd_word;
  logic exp_read;
  logic irq_clr;
  logic [16:0] tx_word;

  // register map; the bus index is the byte address divided by four
  //   idx 0x005 partner_base_ability, filled by base pages, ack set by any page
  //   idx 0x006 autoneg_expansion, page flag consumed by a read
  //   idx 0x007 next_page_transmit, toggle owned by the hardware
  //   idx 0x008 next_page_receive, filled by next pages, ack set by any page
  //   idx 0x00f extended_ability_status, constant abilities
  //   idx 0x010 autoneg_interrupt_control, status and enable
  //   idx 0x011 loopback_position_control, where a loop is made
  //   idx 0x012 loopback enable, stands in for the control bit
  // any other index answers a decode error and reads zero
  // only data bits 15:0 and strobes 1:0 matter; the upper half is dropped

  // assemble a register word; top bit flags a mapped index
  function automatic logic [16:0] read_word(
    input pcsan_pkg::pcsan_regs_t r,
    input logic [9:0] idx
  );
    logic [15:0] w;
    logic hit;
    // the top bit is a hit flag, not data; callers strip it
    w = 16'h0000; // unlisted bits stay zero R22
    hit = 1'h1;
    case (idx)
      // base page fields as the partner sent them, ack set by any page
      `PCSAN_IDX_LP_BASE: begin
        w[`PCSAN_NP_BIT] = r.lp_np; // R1
        w[`PCSAN_ACK_BIT] = r.lp_ack; // R2
        w[`PCSAN_RF_HI:`PCSAN_RF_LO] = r.lp_rf;
        w[`PCSAN_PAUSE_HI:`PCSAN_PAUSE_LO] = r.lp_pause; // R3
        w[`PCSAN_HD_BIT] = r.lp_hd; // R4
        w[`PCSAN_FD_BIT] = r.lp_fd; // R4
      end
      // next-page ability is fixed; the flag clears on read elsewhere
      `PCSAN_IDX_AN_EXP: begin
        w[`PCSAN_NPA_BIT] = 1'h1; // R5
        w[`PCSAN_PRX_BIT] = r.page_rx; // R6
      end
      // toggle comes from the hardware, not from software
      `PCSAN_IDX_NP_TX: begin
        w[`PCSAN_NP_BIT] = r.tx_np; // R7
        w[`PCSAN_MP_BIT] = r.tx_mp; // R8
        w[`PCSAN_ACK2_BIT] = r.tx_ack2;
        w[`PCSAN_TOG_BIT] = r.tx_tog; // R9
        w[`PCSAN_CODE_HI:`PCSAN_CODE_LO] = r.tx_code; // R8
      end
      // last next page from the partner, ack set by any page
      `PCSAN_IDX_NP_RX: begin
        w[`PCSAN_NP_BIT] = r.rx_np; // R10
        w[`PCSAN_ACK_BIT] = r.rx_ack; // R11
        w[`PCSAN_MP_BIT] = r.rx_mp; // R10
        w[`PCSAN_ACK2_BIT] = r.rx_ack2; // R10
        w[`PCSAN_TOG_BIT] = r.rx_tog; // R12
        w[`PCSAN_CODE_HI:`PCSAN_CODE_LO] = r.rx_code; // R10
      end
      // abilities are constants, nothing here is stored
      `PCSAN_IDX_EXT_STAT: begin
        w[`PCSAN_XFD_BIT] = 1'h1; // R13
        // half duplex and base-t abilities left at zero R14
      end
      // status and enable share the low byte
      `PCSAN_IDX_AN_IRQ: begin
        w[`PCSAN_IRQ_ST_BIT] = r.irq_stat;
        w[`PCSAN_IRQ_EN_BIT] = r.irq_en; // R19
      end
      `PCSAN_IDX_LB_POS: begin
        w[`PCSAN_LB_BIT] = r.lb_pos; // R20
      end
      `PCSAN_IDX_LB_CTRL: begin
        w[`PCSAN_LB_BIT] = r.lb_en; // R21
      end
      default: begin
        hit = 1'h0;
      end
    endcase
    return {hit, w};
  endfunction

  // bus timing: a taken address or data half is held in the slave; the
  // write lands one cycle after both halves are in and bvalid rises with
  // it; a read is looked up at its address handshake, so rvalid stands
  // from the next cycle; both answers wait for their ready
  // readies read only flops, so no path runs from a request to a ready
  // handshake readies: one write and one read in flight at a time
  assign awready_c = ~st_q.bus.aw_full & ~st_q.bus.bvalid;
  assign wready_c = ~st_q.bus.w_full & ~st_q.bus.bvalid;
  assign arready_c = ~st_q.bus.rvalid;
  assign aw_hs = axil_req.awvalid & awready_c;
  assign w_hs = axil_req.wvalid & wready_c;
  assign ar_hs = axil_req.arvalid & arready_c;

  // a write is applied one cycle after both halves are held
  // holding both halves first lets them arrive in either order
  assign wr_go = st_q.bus.aw_full & st_q.bus.w_full;

  // read data is looked up at the address handshake
  // the lookup uses araddr as offered, so it must hold until taken
  assign rd_word = read_word(st_q.regs, axil_req.araddr[11:2]);
  assign exp_read = ar_hs & (axil_req.araddr[11:2] == `PCSAN_IDX_AN_EXP);

  // software clears status by writing 0 into the status bit or into the enable bit
  // a write of 1 to the status bit is ignored, it never sets it
  assign irq_clr = wr_go & (st_q.bus.aw_idx == `PCSAN_IDX_AN_IRQ) &
                   st_q.bus.wstrb[0] & ~st_q.bus.wdata[`PCSAN_IRQ_ST_BIT];

  // next state of the bus slave and of the register contents
  // one copy of the whole state is filled here and registered below
  // later assignments win, which sets the order of same-cycle events
  always_comb begin
    st_d = st_q;

    // write address and data are taken in either order
    if (aw_hs) begin
      st_d.bus.aw_full = 1'h1;
      st_d.bus.aw_idx = axil_req.awaddr[11:2];
    end
    if (w_hs) begin
      st_d.bus.w_full = 1'h1;
      st_d.bus.wdata = axil_req.wdata[15:0];
      st_d.bus.wstrb = axil_req.wstrb[1:0];
    end
    // the response drops at the edge where the master takes it
    if (axil_req.bready & st_q.bus.bvalid) begin
      st_d.bus.bvalid = 1'h0;
    end

    // apply a held write; read-only targets answer okay and ignore data
    if (wr_go) begin
      st_d.bus.aw_full = 1'h0;
      st_d.bus.w_full = 1'h0;
      st_d.bus.bvalid = 1'h1;
      st_d.bus.bresp = `PCSAN_RESP_OKAY;
      // each strobe covers one byte; a cleared strobe leaves it alone
      // the toggle and the reserved bit 14 are never writable
      case (st_q.bus.aw_idx)
        `PCSAN_IDX_NP_TX: begin
          if (st_q.bus.wstrb[0]) begin
            st_d.regs.tx_code[7:0] = st_q.bus.wdata[7:0]; // R8
          end
          if (st_q.bus.wstrb[1]) begin
            st_d.regs.tx_np = st_q.bus.wdata[`PCSAN_NP_BIT]; // R7
            st_d.regs.tx_mp = st_q.bus.wdata[`PCSAN_MP_BIT]; // R8
            st_d.regs.tx_ack2 = st_q.bus.wdata[`PCSAN_ACK2_BIT];
            st_d.regs.tx_code[10:8] = st_q.bus.wdata[10:8]; // R8
          end
        end
        `PCSAN_IDX_AN_IRQ: begin
          if (st_q.bus.wstrb[0]) begin
            st_d.regs.irq_en = st_q.bus.wdata[`PCSAN_IRQ_EN_BIT]; // R19
          end
        end
        `PCSAN_IDX_LB_POS: begin
          if (st_q.bus.wstrb[0]) begin
            st_d.regs.lb_pos = st_q.bus.wdata[`PCSAN_LB_BIT]; // R20
          end
        end
        `PCSAN_IDX_LB_CTRL: begin
          if (st_q.bus.wstrb[0]) begin
            st_d.regs.lb_en = st_q.bus.wdata[`PCSAN_LB_BIT]; // R21
          end
        end
        `PCSAN_IDX_LP_BASE, `PCSAN_IDX_AN_EXP, `PCSAN_IDX_NP_RX,
        `PCSAN_IDX_EXT_STAT: begin
          st_d.bus.bresp = `PCSAN_RESP_OKAY; // R22
        end
        default: begin
          st_d.bus.bresp = `PCSAN_RESP_DECERR;
        end
      endcase
    end

    // read channel: data registered at the address handshake
    // a new read waits while the old answer stands
    if (axil_req.rready & st_q.bus.rvalid) begin
      st_d.bus.rvalid = 1'h0;
    end
    if (ar_hs) begin
      st_d.bus.rvalid = 1'h1;
      st_d.bus.rdata = rd_word[15:0];
      st_d.bus.rresp = rd_word[16] ? `PCSAN_RESP_OKAY : `PCSAN_RESP_DECERR;
    end

    // a read of the expansion register consumes the page flag
    // the clear lands at the address handshake, before the data returns
    if (exp_read) begin
      st_d.regs.page_rx = 1'h0; // R6
    end

    // transmit toggle flips on every page the engine sends
    // received pages never move it; only the engine's pulse does
    if (np_tx_sent) begin
      st_d.regs.tx_tog = ~st_q.regs.tx_tog; // R9
    end

    // partner pages; a new page beats a same-cycle read clear
    // ack bits are set by any page, not copied from the word
    // a base page touches only the ack bit of the next-page receive fields
    // fields hold until the next page of the same kind
    if (page_rx.valid) begin
      st_d.regs.page_rx = 1'h1; // R6
      st_d.regs.lp_ack = 1'h1; // R2
      st_d.regs.rx_ack = 1'h1; // R11
      if (page_rx.is_next) begin
        st_d.regs.rx_np = page_rx.word[`PCSAN_NP_BIT]; // R10
        st_d.regs.rx_mp = page_rx.word[`PCSAN_MP_BIT]; // R10
        st_d.regs.rx_ack2 = page_rx.word[`PCSAN_ACK2_BIT]; // R10
        st_d.regs.rx_tog = page_rx.word[`PCSAN_TOG_BIT]; // R12
        st_d.regs.rx_code =
          page_rx.word[`PCSAN_CODE_HI:`PCSAN_CODE_LO]; // R10
      end else begin
        st_d.regs.lp_np = page_rx.word[`PCSAN_NP_BIT]; // R1
        st_d.regs.lp_rf = page_rx.word[`PCSAN_RF_HI:`PCSAN_RF_LO];
        st_d.regs.lp_pause =
          page_rx.word[`PCSAN_PAUSE_HI:`PCSAN_PAUSE_LO]; // R3
        st_d.regs.lp_hd = page_rx.word[`PCSAN_HD_BIT]; // R4
        st_d.regs.lp_fd = page_rx.word[`PCSAN_FD_BIT]; // R4
      end
    end

    // status: clear by writing 0, completion sets and wins over it
    // order matters: clear, then set, then the enable forces zero
    // so a completion never slips past a clear written in its cycle
    if (irq_clr) begin
      st_d.regs.irq_stat = 1'h0; // R16
    end
    if (an_complete & st_d.regs.irq_en) begin
      st_d.regs.irq_stat = 1'h1; // R15
    end
    // disabling wipes the status, including a same-cycle completion
    if (~st_d.regs.irq_en) begin
      st_d.regs.irq_stat = 1'h0; // R17
    end
  end

  // state register with synchronous active-low reset
  // a synchronous reset keeps every flop on the one clock
  // nonzero defaults are laid over an all-zero state
  // lb_pos comes from the attribute so a board picks its default
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.regs.tx_mp <= `PCSAN_TX_MP_RST; // R8
      st_q.regs.tx_code <= `PCSAN_TX_CODE_RST; // R8
      st_q.regs.irq_en <= `PCSAN_IRQ_EN_RST; // R19
      st_q.regs.lb_pos <= loopback_position_init_attr; // R20
    end else begin
      st_q <= st_d;
    end
  end

  // bus answers; data and responses come straight from flops
  // readies are combinational so a request is taken in its first cycle
  always_comb begin
    axil_rsp = '0;
    axil_rsp.awready = awready_c;
    axil_rsp.wready = wready_c;
    axil_rsp.bvalid = st_q.bus.bvalid;
    axil_rsp.bresp = st_q.bus.bresp;
    axil_rsp.arready = arready_c;
    axil_rsp.rvalid = st_q.bus.rvalid;
    axil_rsp.rdata = {16'h0000, st_q.bus.rdata}; // upper half reads zero
    axil_rsp.rresp = st_q.bus.rresp;
  end

  // next page word offered to the engine, toggle included
  // the word is built by the same lookup that software reads
  assign tx_word = read_word(st_q.regs, `PCSAN_IDX_NP_TX);
  assign np_tx_word = tx_word[15:0];

  // position alone never loops data back; the enable gates both paths
  // only one path can be active, since lb_pos picks between them
  assign loopback_mac_en = st_q.regs.lb_en & ~st_q.regs.lb_pos; // R21
  assign loopback_xcvr_en = st_q.regs.lb_en & st_q.regs.lb_pos; // R21

  // interrupt pin is the status flop itself, no extra delay
  // software reads the same level that the pin shows
  assign autoneg_done_irq_out = st_q.regs.irq_stat; // R18

endmodule
`default_nettype wire

// ===== tb/pcsan_regs_asserts.sv
// concurrent checks on the register bank ports
`default_nettype none
module pcsan_regs_asserts (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus and engine
  input wire pcsan_pkg::pcsan_axil_req_t axil_req,
  input wire pcsan_pkg::pcsan_axil_rsp_t axil_rsp,
  input wire pcsan_pkg::pcsan_page_t page_rx,
  input wire logic np_tx_sent,
  input wire logic an_complete,
  // outputs
  input wire logic [15:0] np_tx_word,
  input wire logic loopback_mac_en,
  input wire logic loopback_xcvr_en,
  input wire logic autoneg_done_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // answers stand until the master takes them
  a_b_holds: assert property (axil_rsp.bvalid && !axil_req.bready |=>
    axil_rsp.bvalid && $stable(axil_rsp.bresp)) else $error("bresp moved");
  a_r_holds: assert property (axil_rsp.rvalid && !axil_req.rready |=>
    axil_rsp.rvalid && $stable(axil_rsp.rdata)) else $error("rdata moved");
  a_read_answer: assert property (axil_req.arvalid && axil_rsp.arready
    |=> axil_rsp.rvalid) else $error("read not answered");
  a_upper_zero: assert property (
    axil_rsp.rvalid |-> axil_rsp.rdata[31:16] == 16'h0) else $error("upper");
  a_lb_single: assert property (
    !(loopback_mac_en && loopback_xcvr_en)) else $error("two loopbacks");
  a_irq_cause: assert property (
    $rose(autoneg_done_irq_out) |-> $past(an_complete)) else $error("irq");
  // status only drops by a register write, seen as the write response
  a_irq_hold: assert property (
    $fell(autoneg_done_irq_out) |-> $rose(axil_rsp.bvalid))
    else $error("irq dropped");
  a_tx_toggle: assert property (np_tx_sent |=>
    np_tx_word[11] != $past(np_tx_word[11])) else $error("toggle");
endmodule

bind pcsan_regs pcsan_regs_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .page_rx(page_rx),
  .np_tx_sent(np_tx_sent), .an_complete(an_complete),
  .np_tx_word(np_tx_word), .loopback_mac_en(loopback_mac_en),
  .loopback_xcvr_en(loopback_xcvr_en),
  .autoneg_done_irq_out(autoneg_done_irq_out));
`default_nettype wire

// ===== tb/pcsan_engine_model.sv
// negotiation engine stand-in driving pages and events
`default_nettype none
module pcsan_engine_model (
  // clock
  input wire logic aclk,
  // engine events
  output var pcsan_pkg::pcsan_page_t page_rx,
  output var logic np_tx_sent,
  output var logic an_complete
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at time zero
  initial begin
    page_rx = '0;
    np_tx_sent = 1'h0;
    an_complete = 1'h0;
  end
  // one-cycle page; the word is inverted after so stale data never matches
  task automatic page(input logic nx, input logic [15:0] w);
    page_rx <= '{1'h1, nx, w};
    @(posedge aclk);
    page_rx <= '{1'h0, 1'h0, ~w};
  endtask
  // one-cycle completion or page-sent pulse
  task automatic pulse(input logic done);
    if (done) an_complete <= 1'h1;
    else np_tx_sent <= 1'h1;
    @(posedge aclk);
    an_complete <= 1'h0;
    np_tx_sent <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_pcs_autoneg_mgmt_registers.sv
// self-checking bench for the negotiation register bank
`default_nettype none
module tb_pcs_autoneg_mgmt_registers;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  pcsan_pkg::pcsan_axil_req_t req = '0;
  pcsan_pkg::pcsan_axil_rsp_t rsp;
  pcsan_pkg::pcsan_page_t pg;
  logic sent, done, irq, lb_mac, lb_xcvr;
  logic [15:0] txw;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  // 50 MHz clock
  always #10 aclk = ~aclk;
  pcsan_regs dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .page_rx(pg), .np_tx_sent(sent), .an_complete(done),
    .np_tx_word(txw), .loopback_mac_en(lb_mac), .loopback_xcvr_en(lb_xcvr),
    .autoneg_done_irq_out(irq));
  pcsan_engine_model eng (.aclk(aclk), .page_rx(pg), .np_tx_sent(sent),
    .an_complete(done));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // cut a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // write; readies sampled mid-cycle so each half drops at its own edge
  task automatic wr(input logic [9:0] i, input logic [15:0] d,
      input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    req.awaddr <= {i, 2'h0};
    req.wdata <= {16'h0, d};
    req.awvalid <= 1'h1;
    req.wvalid <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge aclk);
      ha = req.awvalid & rsp.awready;
      hw = req.wvalid & rsp.wready;
      hb = rsp.bvalid & req.bready;
      r = rsp.bresp;
      @(posedge aclk);
      if (ha) req.awvalid <= 1'h0;
      if (hw) req.wvalid <= 1'h0;
    end
    chk({14'h0, r}, {14'h0, er});
  endtask
  task automatic rd(input logic [9:0] i, input logic [15:0] e,
      input logic [1:0] er);
    logic ha, hr;
    logic [31:0] d;
    logic [1:0] r;
    req.araddr <= {i, 2'h0};
    req.arvalid <= 1'h1;
    hr = 1'h0;
    while (!hr) begin
      @(negedge aclk);
      ha = req.arvalid & rsp.arready;
      hr = rsp.rvalid & req.rready;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ha) req.arvalid <= 1'h0;
    end
    chk(d[15:0], e);
    chk({14'h0, r}, {14'h0, er});
  endtask
  // reset values, then an unmapped index
  task automatic t_reset();
    rd(10'h005, 16'h0000, 2'h0);
    rd(10'h006, 16'h0004, 2'h0);
    rd(10'h007, 16'h2001, 2'h0);
    rd(10'h008, 16'h0000, 2'h0);
    rd(10'h00f, 16'h8000, 2'h0);
    rd(10'h010, 16'h0001, 2'h0);
    rd(10'h011, 16'h0000, 2'h0);
    rd(10'h012, 16'h0000, 2'h0);
    rd(10'h013, 16'h0000, 2'h3);
    chk(txw, 16'h2001);
  endtask
  // partner pages: every pause code, flags, clear on read
  task automatic t_pages();
    for (int p = 0; p < 4; p++) begin
      eng.page(1'h0, {7'h0, p[1:0], 7'h7f});
      rd(10'h005, {7'h20, p[1:0], 7'h60}, 2'h0);
    end
    eng.page(1'h0, 16'hffff);
    rd(10'h005, 16'hf1e0, 2'h0);
    rd(10'h006, 16'h0006, 2'h0);
    rd(10'h006, 16'h0004, 2'h0);
    rd(10'h008, 16'h4000, 2'h0);
    eng.page(1'h1, 16'h3fff);
    rd(10'h008, 16'h7fff, 2'h0);
    eng.page(1'h1, 16'h37ff);
    rd(10'h008, 16'h77ff, 2'h0);
    eng.page(1'h1, 16'h8801);
    rd(10'h008, 16'hc801, 2'h0);
    wr(10'h005, 16'h0000, 2'h0);
    rd(10'h005, 16'hf1e0, 2'h0);
  endtask
  // transmit word and its toggle
  task automatic t_tx();
    wr(10'h007, 16'hffff, 2'h0);
    rd(10'h007, 16'hb7ff, 2'h0);
    chk(txw, 16'hb7ff);
    eng.pulse(1'h0);
    rd(10'h007, 16'hbfff, 2'h0);
    eng.pulse(1'h0);
    wr(10'h007, 16'h0000, 2'h0);
    rd(10'h007, 16'h0000, 2'h0);
  endtask
  // completion interrupt: set, hold, clear, forced off
  task automatic t_irq();
    eng.pulse(1'h1);
    rd(10'h010, 16'h0003, 2'h0);
    chk({15'h0, irq}, 16'h0001);
    wr(10'h010, 16'hffff, 2'h0);
    rd(10'h010, 16'h0003, 2'h0);
    wr(10'h010, 16'h0001, 2'h0);
    chk({15'h0, irq}, 16'h0000);
    eng.pulse(1'h1);
    wr(10'h010, 16'h0002, 2'h0);
    chk({15'h0, irq}, 16'h0000);
    eng.pulse(1'h1);
    rd(10'h010, 16'h0000, 2'h0);
    wr(10'h010, 16'h0001, 2'h0);
    rd(10'h010, 16'h0001, 2'h0);
  endtask
  // position alone must not start loopback
  task automatic t_loop();
    wr(10'h011, 16'hffff, 2'h0);
    rd(10'h011, 16'h0001, 2'h0);
    chk({14'h0, lb_mac, lb_xcvr}, 16'h0000);
    wr(10'h012, 16'h0001, 2'h0);
    rd(10'h012, 16'h0001, 2'h0);
    chk({14'h0, lb_mac, lb_xcvr}, 16'h0001);
    wr(10'h011, 16'h0000, 2'h0);
    chk({14'h0, lb_mac, lb_xcvr}, 16'h0002);
    wr(10'h013, 16'h0001, 2'h3);
  endtask
  // answers must stand while the master holds its ready low
  task automatic t_stall();
    req.bready <= 1'h0;
    req.rready <= 1'h0;
    fork
      begin
        repeat (3) @(posedge aclk);
        req.rready <= 1'h1;
      end
      rd(10'h00f, 16'h8000, 2'h0);
    join
    fork
      begin
        repeat (4) @(posedge aclk);
        req.bready <= 1'h1;
      end
      wr(10'h013, 16'h0000, 2'h3);
    join
  endtask
  // bready and rready rest high; one scenario holds them low a while
  initial begin
    req.wstrb = 4'hf;
    req.bready = 1'h1;
    req.rready = 1'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_reset();
    t_pages();
    t_tx();
    t_irq();
    t_loop();
    t_stall();
    give_verdict();
  end
endmodule
`default_nettype wire
